// File: core/sfp_protect.sv
// Two-channel fault protection and latching core
`timescale 1ns/100ps
`include "sfp_params.svh"
module sfp_protect #(
  parameter int CNT_W      = `SFP_CNT_W,
  parameter int RETRY_W    = `SFP_RETRY_W,
  parameter int T_FAULT_NS = `SFP_T_FAULT_NS
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_b_i,
  // Control
  input  wire logic [1:0]              on_req_i,
  input  wire logic [1:0]              load_profile_select_i,
  input  wire logic                    supply_high_protect_disable_i,
  input  wire logic [1:0]              retry_enable_i,
  input  wire logic [RETRY_W-1:0]      retry_limit_i,
  input  wire logic [CNT_W-1:0]        win1_width_i,
  input  wire logic [CNT_W-1:0]        win2_width_i,
  input  wire logic [1:0]              delatch_i,
  input  wire logic [1:0]              fault_read_i,
  input  wire logic                    status_read_i,
  // Comparator flags
  input  wire logic [1:0]              overtemp_flag_i,
  input  wire logic [1:0]              oc_high_flag_i,
  input  wire logic [1:0]              oc_mid_flag_i,
  input  wire logic [1:0]              oc_low_flag_i,
  input  wire logic [1:0]              short_flag_i,
  input  wire logic                    supply_high_flag_i,
  // Outputs
  output logic [1:0]                   channel_on_o,
  output sfp_pkg::sfp_fault_type       channel_fault_register0_o,
  output sfp_pkg::sfp_fault_type       channel_fault_register1_o,
  output logic                         supply_high_fault_bit_o,
  output logic                         fault_indicator_n_o,
  output logic                         sense_valid_strobe_n_o,
  output logic [1:0]                   sense_enable_o
);
  import sfp_pkg::*;

  localparam int TF_CYC = (T_FAULT_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS;
  localparam int TF_W   = $clog2(TF_CYC + 1) + 1;

  if (CNT_W < 2 || RETRY_W < 1 || TF_CYC < 1) begin : gen_param_check
    $error("sfp_protect: unsupported parameter values");
  end

  logic [1:0]         ot_bit_reg;
  logic [1:0]         oc_bit_reg;
  logic [1:0]         sc_bit_reg;
  logic [1:0]         oc_latch_reg;
  logic [1:0]         oc_off_reg;
  logic [1:0]         ot_off_reg;
  logic [1:0]         on_prev_reg;
  logic [1:0]         on_clean_reg;
  logic [1:0]         oc_wait_reg;
  logic [1:0]         ind_ot_reg;
  logic               ov_off_reg;
  logic               ov_bit_reg;
  logic [CNT_W-1:0]   dur_reg [2];
  logic [TF_W-1:0]    tf_cnt_reg [2];
  logic [RETRY_W-1:0] retry_cnt_reg [2];
  sfp_win_type        win_reg [2];
  logic [1:0]         ch_on;
  logic [1:0]         turn_on;
  logic [1:0]         turn_off;
  logic [1:0]         win_act;
  logic [1:0]         oc_det;
  logic [1:0]         retry_left;
  logic               ov_act;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  assign ov_act = supply_high_flag_i && !supply_high_protect_disable_i;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ch_on[c]      = on_req_i[c] && !oc_latch_reg[c] && !sc_bit_reg[c] && !ot_off_reg[c]
                      && !overtemp_flag_i[c] && !oc_off_reg[c] && !ov_off_reg && !ov_act;
      turn_on[c]    = ch_on[c] && !on_prev_reg[c];
      turn_off[c]   = !ch_on[c] && on_prev_reg[c];
      retry_left[c] = retry_enable_i[c] && (retry_cnt_reg[c] < retry_limit_i);
      if (load_profile_select_i[c]) begin
        win_act[c] = (win_reg[c] == SFP_WIN_FIRST);
        oc_det[c]  = ch_on[c] && (oc_high_flag_i[c] || (win_act[c] && dur_reg[c] > win1_width_i));
      end else begin
        win_act[c] = (win_reg[c] == SFP_WIN_FIRST) || (win_reg[c] == SFP_WIN_SECND);
        oc_det[c]  = ch_on[c] && (oc_high_flag_i[c]
                     || (win_reg[c] == SFP_WIN_SECND && oc_mid_flag_i[c])
                     || (win_reg[c] == SFP_WIN_DONE && oc_low_flag_i[c])
                     || (win_reg[c] == SFP_WIN_FIRST && dur_reg[c] > win1_width_i)
                     || (win_reg[c] == SFP_WIN_SECND && dur_reg[c] > win2_width_i));
      end
    end
  end

  // Channel drive and edge tracking
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_prev_reg  <= 2'b00;
      channel_on_o <= 2'b00;
    end else begin
      on_prev_reg  <= ch_on;
      channel_on_o <= ch_on;
    end
  end

  // Overtemperature shut-off, retry and fault bit
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ot_bit_reg <= 2'b00;
      ot_off_reg <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (overtemp_flag_i[c]) begin
          ot_bit_reg[c] <= 1'b1;
          ot_off_reg[c] <= 1'b1;
        end else begin
          if (fault_read_i[c] && fault_indicator_n_o) begin
            ot_bit_reg[c] <= 1'b0;
          end
          if (retry_enable_i[c] || delatch_i[c]) begin
            ot_off_reg[c] <= 1'b0;
          end
        end
      end
    end
  end

  // Fault indicator hold for overtemperature
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ind_ot_reg <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (overtemp_flag_i[c]) begin
          ind_ot_reg[c] <= 1'b1;
        end else if ((|turn_on) && !(|overtemp_flag_i)) begin
          ind_ot_reg[c] <= 1'b0;
        end
      end
    end
  end

  // Overcurrent reaction delay, latching and retry count
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oc_wait_reg  <= 2'b00;
      oc_latch_reg <= 2'b00;
      oc_off_reg   <= 2'b00;
      oc_bit_reg   <= 2'b00;
      sc_bit_reg   <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        tf_cnt_reg[c]    <= '0;
        retry_cnt_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        oc_off_reg[c] <= 1'b0;
        if (delatch_i[c]) begin
          oc_latch_reg[c]  <= 1'b0;
          retry_cnt_reg[c] <= '0;
        end
        if (fault_read_i[c] && !oc_latch_reg[c]) begin
          oc_bit_reg[c] <= 1'b0;
        end
        if (fault_read_i[c] && delatch_i[c] && !short_flag_i[c]) begin
          sc_bit_reg[c] <= 1'b0;
        end
        if (turn_on[c] && short_flag_i[c]) begin
          sc_bit_reg[c] <= 1'b1;
        end
        if (oc_det[c] && !oc_wait_reg[c]) begin
          oc_wait_reg[c] <= 1'b1;
          tf_cnt_reg[c]  <= '0;
        end else if (oc_wait_reg[c]) begin
          tf_cnt_reg[c] <= tf_cnt_reg[c] + {{(TF_W-1){1'b0}}, 1'b1};
          if (tf_cnt_reg[c] == TF_W'(TF_CYC - 1)) begin
            oc_wait_reg[c] <= 1'b0;
            oc_bit_reg[c]  <= 1'b1;
            if (retry_left[c]) begin
              oc_off_reg[c]    <= 1'b1;
              retry_cnt_reg[c] <= retry_cnt_reg[c] + {{(RETRY_W-1){1'b0}}, 1'b1};
            end else begin
              oc_latch_reg[c] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Window profile state and duration counter
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_clean_reg <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        win_reg[c] <= SFP_WIN_IDLE;
        dur_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (turn_on[c]) begin
          on_clean_reg[c] <= 1'b1;
        end else if (oc_det[c] || (ch_on[c] && oc_low_flag_i[c])) begin
          on_clean_reg[c] <= 1'b0;
        end
        if (delatch_i[c]) begin
          dur_reg[c] <= '0;
          win_reg[c] <= SFP_WIN_IDLE;
        end else if (load_profile_select_i[c]) begin
          if (turn_off[c] && on_clean_reg[c]) begin
            dur_reg[c] <= '0;
            win_reg[c] <= SFP_WIN_IDLE;
          end else if (ch_on[c] && oc_low_flag_i[c] && win_reg[c] == SFP_WIN_IDLE) begin
            win_reg[c] <= SFP_WIN_FIRST;
          end else if (ch_on[c] && win_act[c]) begin
            dur_reg[c] <= sat_inc(dur_reg[c]);
          end
        end else begin
          if (oc_wait_reg[c] && tf_cnt_reg[c] == TF_W'(TF_CYC - 1) && retry_left[c]) begin
            dur_reg[c] <= '0;
            win_reg[c] <= SFP_WIN_IDLE;
          end else if (turn_on[c] && win_reg[c] == SFP_WIN_IDLE) begin
            win_reg[c] <= SFP_WIN_FIRST;
          end else if (ch_on[c] && win_act[c]) begin
            if (win_reg[c] == SFP_WIN_FIRST && dur_reg[c] >= win1_width_i && !oc_mid_flag_i[c]) begin
              win_reg[c] <= SFP_WIN_SECND;
              dur_reg[c] <= '0;
            end else if (win_reg[c] == SFP_WIN_SECND && dur_reg[c] >= win2_width_i && !oc_low_flag_i[c]) begin
              win_reg[c] <= SFP_WIN_DONE;
              dur_reg[c] <= '0;
            end else begin
              dur_reg[c] <= sat_inc(dur_reg[c]);
            end
          end
        end
      end
    end
  end

  // Supply overvoltage hold and warning bit
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ov_off_reg <= 1'b0;
      ov_bit_reg <= 1'b0;
    end else begin
      ov_off_reg <= ov_act;
      if (supply_high_flag_i) begin
        ov_bit_reg <= 1'b1;
      end else if (status_read_i) begin
        ov_bit_reg <= 1'b0;
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_fault_register0_o <= '0;
      channel_fault_register1_o <= '0;
      supply_high_fault_bit_o   <= 1'b0;
      fault_indicator_n_o       <= 1'b1;
      sense_valid_strobe_n_o    <= 1'b1;
      sense_enable_o            <= 2'b00;
    end else begin
      channel_fault_register0_o <= {ot_bit_reg[0], sc_bit_reg[0], oc_bit_reg[0]};
      channel_fault_register1_o <= {ot_bit_reg[1], sc_bit_reg[1], oc_bit_reg[1]};
      supply_high_fault_bit_o   <= ov_bit_reg;
      fault_indicator_n_o       <= !((|ind_ot_reg) || (|overtemp_flag_i) || (|oc_latch_reg)
                                   || (|sc_bit_reg) || ov_act || ov_off_reg);
      sense_valid_strobe_n_o    <= (|(win_act & ch_on)) || !(|ch_on);
      sense_enable_o            <= ch_on & ~win_act;
    end
  end

  chk_ot_shutoff: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    overtemp_flag_i[0] |=> !channel_on_o[0] && !fault_indicator_n_o) else $error("overtemp not shut");
  chk_ov_both: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (supply_high_flag_i && !supply_high_protect_disable_i) |=> channel_on_o == 2'b00) else $error("ov on");
  chk_ov_warn: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    supply_high_flag_i |-> ##2 supply_high_fault_bit_o) else $error("ov bit missing");
  chk_supply_high_protect_disable_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (supply_high_protect_disable_i && !ov_off_reg && !(|ind_ot_reg) && !(|overtemp_flag_i) && !(|oc_latch_reg)
    && !(|sc_bit_reg)) |=> fault_indicator_n_o) else $error("ind low");
  chk_sense_blank: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (win_act[0] && ch_on[0]) |=> sense_valid_strobe_n_o && !sense_enable_o[0]) else $error("sense not blanked");
  chk_oc_delay: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (oc_wait_reg[0] && tf_cnt_reg[0] == TF_W'(TF_CYC - 1)) |=> oc_bit_reg[0] && !oc_wait_reg[0])
    else $error("oc delay wrong");
  chk_oc_count: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (oc_wait_reg[0] && tf_cnt_reg[0] != TF_W'(TF_CYC - 1)) |=> oc_wait_reg[0]
    && tf_cnt_reg[0] == $past(tf_cnt_reg[0]) + TF_W'(1)) else $error("oc count wrong");
  chk_retry_off: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    oc_off_reg[0] |=> !channel_on_o[0]) else $error("retry not off");
  chk_sc_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (turn_on[1] && short_flag_i[1]) |=> sc_bit_reg[1] ##1 !channel_on_o[1]) else $error("short not latched");
  chk_fault_map: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    channel_fault_register0_o == $past({ot_bit_reg[0], sc_bit_reg[0], oc_bit_reg[0]})) else $error("map");
  chk_ot_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ot_bit_reg[0] && !fault_read_i[0]) |=> ot_bit_reg[0]) else $error("ot bit lost");
  chk_ot_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ind_ot_reg[0] && !(|turn_on)) |=> ind_ot_reg[0]) else $error("indicator released early");
  chk_motor_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (load_profile_select_i[0] && !delatch_i[0] && turn_off[0] && on_clean_reg[0]) |=> dur_reg[0] == '0)
    else $error("motor counter kept");
  chk_motor_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (load_profile_select_i[0] && !delatch_i[0] && turn_off[0] && !on_clean_reg[0])
    |=> dur_reg[0] == $past(dur_reg[0])) else $error("motor counter lost");

  cov_oc_trip: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(oc_bit_reg[0]));
  cov_lamp_second: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) win_reg[0] == SFP_WIN_SECND);
  cov_motor_win: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    load_profile_select_i[1] && win_reg[1] == SFP_WIN_FIRST);
  cov_ov_off: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(ov_off_reg));
  cov_oc_retry: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $rose(oc_off_reg[0]));
endmodule

// File: core/sfp_params.svh
// Constants for the switch fault protection logic
// Notes on behaviour
// - Per-channel overtemperature turns off, latches, pulls indicator
// - Overtemperature detected while on or off
// - Indicator released on turn-on with no overtemperature
// - Auto-retry restarts channel after overtemperature clears
// - Overtemperature bit clears on fault read when safe
// - Overcurrent turns channel off after reaction delay
// - Overcurrent on threshold cross or window overrun
// - Sense blanked, strobe high while window active
// - Profile select low lighting, high motor
// - Lighting: two windows from first turn-on, again after delatch or retry
// - Motor: one window opened above low threshold
// - With retry, overcurrent latches after retries exhausted
// - Counter accumulates only during on-times
// - Counter reset on delatch, lighting also on retry
// - Motor: clean on-period resets counter at turn-off
// - PWM edges alone never reset the counter
// - Short at turn-on shuts off and latches
// - Supply overvoltage turns both off, sets bit
// - Stay off until supply drops; status read clears
// - Disable bit keeps only the warning bit
// - Fault bits: overcurrent 0, short 1, overtemp 2
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
`define SFP_FLT_OC      0
`define SFP_FLT_SC      1
`define SFP_FLT_OT      2
`define SFP_FLT_W       3
`define SFP_CNT_W       16
`define SFP_RETRY_W     4
`define SFP_T_FAULT_NS  1000
`define SFP_CLK_NS      20
`define SFP_T_FAULT_CYC ((`SFP_T_FAULT_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_DFLT_W1     16'h0100
`define SFP_DFLT_W2     16'h0400
`define SFP_DFLT_RETRY  4'h3
`endif

// File: core/sfp_pkg.sv
// Types for the switch fault protection logic
`include "sfp_params.svh"
package sfp_pkg;
  typedef logic [`SFP_FLT_W-1:0] sfp_fault_type;
  typedef enum logic [1:0] {
    SFP_WIN_IDLE  = 2'b00,
    SFP_WIN_FIRST = 2'b01,
    SFP_WIN_SECND = 2'b11,
    SFP_WIN_DONE  = 2'b10
  } sfp_win_type;
endpackage

// File: verification/test_sfp_protect.sv
// Self-checking testbench for the switch fault protection core
`timescale 1ns/100ps
module test_sfp_protect;
  import sfp_pkg::*;
  typedef struct packed {
    logic [1:0]    ot;
    logic [1:0]    sc;
    logic [1:0]    och;
    logic          ov;
    logic          ovd;
    logic [1:0]    on;
    sfp_fault_type f0;
    sfp_fault_type f1;
    logic          ovb;
    logic          ind;
  } sfp_row_type;
  logic          ref_clk_i, rst_b_i, supply_high_protect_disable_i, status_read_i, supply_high_flag_i;
  logic [1:0]    on_req_i, load_profile_select_i, retry_enable_i, delatch_i, fault_read_i;
  logic [1:0]    overtemp_flag_i, oc_high_flag_i, oc_mid_flag_i, oc_low_flag_i, short_flag_i;
  logic [3:0]    retry_limit_i;
  logic [15:0]   win1_width_i, win2_width_i;
  logic [1:0]    channel_on_o, sense_enable_o;
  sfp_fault_type f0, f1;
  logic          ovb, ind, strobe, was_on;
  int            err_count, checks, n, ups;
  sfp_row_type   rows [6];

  sfp_protect #(.T_FAULT_NS(40)) dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .on_req_i(on_req_i),
    .load_profile_select_i(load_profile_select_i),
    .supply_high_protect_disable_i(supply_high_protect_disable_i),
    .retry_enable_i(retry_enable_i), .retry_limit_i(retry_limit_i),
    .win1_width_i(win1_width_i), .win2_width_i(win2_width_i), .delatch_i(delatch_i),
    .fault_read_i(fault_read_i), .status_read_i(status_read_i), .overtemp_flag_i(overtemp_flag_i),
    .oc_high_flag_i(oc_high_flag_i), .oc_mid_flag_i(oc_mid_flag_i), .oc_low_flag_i(oc_low_flag_i),
    .short_flag_i(short_flag_i), .supply_high_flag_i(supply_high_flag_i), .channel_on_o(channel_on_o),
    .channel_fault_register0_o(f0), .channel_fault_register1_o(f1), .supply_high_fault_bit_o(ovb),
    .fault_indicator_n_o(ind), .sense_valid_strobe_n_o(strobe), .sense_enable_o(sense_enable_o)
  );

  initial begin
    ref_clk_i = 1'h0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  task automatic rst();
    @(negedge ref_clk_i);
    rst_b_i = 1'h0;
    {on_req_i, load_profile_select_i, retry_enable_i, delatch_i, fault_read_i} = 10'h000;
    {overtemp_flag_i, oc_high_flag_i, oc_mid_flag_i, oc_low_flag_i, short_flag_i} = 10'h000;
    {supply_high_protect_disable_i, status_read_i, supply_high_flag_i} = 3'h0;
    retry_limit_i = 4'h2;
    win1_width_i = 16'h0010;
    win2_width_i = 16'h0020;
    cyc(3);
    chk({ind, strobe, channel_on_o, ovb, sense_enable_o}, 8'h60);
    rst_b_i = 1'h1;
  endtask

  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    err_count = 0;
    checks = 0;
    rst_b_i = 1'h0;
    rows[0] = '{2'h0, 2'h0, 2'h0, 1'h0, 1'h0, 2'h3, 3'h0, 3'h0, 1'h0, 1'h1};
    rows[1] = '{2'h1, 2'h0, 2'h0, 1'h0, 1'h0, 2'h2, 3'h4, 3'h0, 1'h0, 1'h0};
    rows[2] = '{2'h0, 2'h2, 2'h0, 1'h0, 1'h0, 2'h1, 3'h0, 3'h2, 1'h0, 1'h0};
    rows[3] = '{2'h0, 2'h0, 2'h1, 1'h0, 1'h0, 2'h2, 3'h1, 3'h0, 1'h0, 1'h0};
    rows[4] = '{2'h0, 2'h0, 2'h0, 1'h1, 1'h0, 2'h0, 3'h0, 3'h0, 1'h1, 1'h0};
    rows[5] = '{2'h0, 2'h0, 2'h0, 1'h1, 1'h1, 2'h3, 3'h0, 3'h0, 1'h1, 1'h1};
    foreach (rows[i]) begin
      rst();
      on_req_i = 2'h3;
      {overtemp_flag_i, short_flag_i, oc_high_flag_i} = {rows[i].ot, rows[i].sc, rows[i].och};
      {supply_high_flag_i, supply_high_protect_disable_i} = {rows[i].ov, rows[i].ovd};
      cyc(10);
      chk({channel_on_o, f0, f1}, {rows[i].on, rows[i].f0, rows[i].f1});
      chk({ovb, ind}, {rows[i].ovb, rows[i].ind});
      $display("row %0d done", i);
    end
    // Overtemperature release and bit clear
    rst();
    on_req_i = 2'h3;
    overtemp_flag_i = 2'h1;
    cyc(3);
    fault_read_i = 2'h1;
    cyc(1);
    fault_read_i = 2'h0;
    cyc(2);
    chk(f0[2], 1'h1);
    overtemp_flag_i = 2'h0;
    cyc(3);
    chk(ind, 1'h0);
    delatch_i = 2'h1;
    on_req_i = 2'h2;
    cyc(1);
    delatch_i = 2'h0;
    cyc(2);
    on_req_i = 2'h3;
    for (n = 0; n < 20 && ind !== 1'h1; n++) cyc(1);
    chk({ind, f0}, 4'hc);
    fault_read_i = 2'h1;
    cyc(1);
    fault_read_i = 2'h0;
    cyc(2);
    chk(f0[2], 1'h0);
    $display("overtemp clear done");
    // Overtemperature while off, then auto-retry restart
    rst();
    overtemp_flag_i = 2'h2;
    cyc(3);
    overtemp_flag_i = 2'h0;
    cyc(3);
    chk({ind, f1[2]}, 2'h1);
    rst();
    retry_enable_i = 2'h1;
    on_req_i = 2'h1;
    overtemp_flag_i = 2'h1;
    cyc(3);
    chk(channel_on_o[0], 1'h0);
    overtemp_flag_i = 2'h0;
    for (n = 0; n < 100 && channel_on_o[0] !== 1'h1; n++) cyc(1);
    chk(channel_on_o[0], 1'h1);
    $display("overtemp off and retry done");
    // Supply overvoltage hold and status read
    rst();
    on_req_i = 2'h3;
    supply_high_flag_i = 1'h1;
    cyc(3);
    status_read_i = 1'h1;
    cyc(1);
    status_read_i = 1'h0;
    cyc(2);
    chk({ovb, channel_on_o}, 3'h4);
    supply_high_flag_i = 1'h0;
    for (n = 0; n < 100 && channel_on_o !== 2'h3; n++) cyc(1);
    status_read_i = 1'h1;
    cyc(1);
    status_read_i = 1'h0;
    cyc(2);
    chk({ovb, channel_on_o}, 3'h3);
    $display("overvoltage done");
    // Sense blanking across the lighting windows
    rst();
    on_req_i = 2'h3;
    cyc(4);
    chk({strobe, sense_enable_o}, 3'h4);
    for (n = 0; n < 300 && strobe !== 1'h0; n++) cyc(1);
    chk({strobe, sense_enable_o}, 3'h3);
    $display("sense blanking done");
    // Motor window overrun, continuous and in switch mode
    for (int sw = 0; sw < 2; sw++) begin
      rst();
      load_profile_select_i = 2'h1;
      on_req_i = 2'h3;
      oc_low_flag_i = 2'h1;
      cyc(12);
      chk({channel_on_o, f0}, 5'h18);
      for (n = 0; n < 400 && f0[0] !== 1'h1; n++) begin
        if (sw == 1)
          on_req_i[0] = n[2];
        cyc(1);
      end
      chk({channel_on_o[0], f0[0]}, 2'h1);
      $display("motor overrun %0d done", sw);
    end
    // Lighting first window overrun on the middle threshold
    rst();
    on_req_i = 2'h1;
    oc_mid_flag_i = 2'h1;
    cyc(12);
    chk({channel_on_o[0], f0[0]}, 2'h2);
    for (n = 0; n < 100 && f0[0] !== 1'h1; n++) cyc(1);
    chk({channel_on_o[0], f0[0]}, 2'h1);
    $display("lighting overrun done");
    // Motor counter reset after a clean on-period
    rst();
    load_profile_select_i = 2'h1;
    on_req_i = 2'h1;
    oc_low_flag_i = 2'h1;
    cyc(12);
    {on_req_i, oc_low_flag_i} = 4'h0;
    cyc(1);
    on_req_i = 2'h1;
    cyc(4);
    on_req_i = 2'h0;
    cyc(1);
    {on_req_i, oc_low_flag_i} = 4'h5;
    cyc(14);
    chk({channel_on_o[0], f0[0]}, 2'h2);
    $display("motor reset done");
    // Overcurrent with retries before latching
    rst();
    retry_enable_i = 2'h1;
    on_req_i = 2'h1;
    oc_high_flag_i = 2'h1;
    for (n = 0; n < 100 && f0[0] !== 1'h1; n++) cyc(1);
    chk({channel_on_o[0], f0[0]}, 2'h1);
    ups = 1;
    was_on = 1'h0;
    for (n = 0; n < 200; n++) begin
      cyc(1);
      if (channel_on_o[0] === 1'h1 && was_on !== 1'h1)
        ups++;
      was_on = channel_on_o[0];
    end
    chk({channel_on_o[0], ind, ups[3:0]}, {2'h0, retry_limit_i + 4'h1});
    $display("overcurrent retry done");
    test_done();
  end
endmodule
